// ===== ckgen_clock_control.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - After reset CPU clock is slow oscillator divided 8
// - Peripheral clock only while gate bit set
// - Slow and watchdog oscillator sources provided; fast oscillator has an enable only
// - PLL rate from multiply and divide fields
// - Multiply codes 1..4 mean x2,x4,x6,x8
// - Divide codes 0..2 mean /1,/2,/4
// - Feedback resistor connected while bit 3 low
// - Slow oscillator stops while bit 4 high
// - Protected registers writable only with protect bit
module ckgen_clock_control #(
    parameter int SLOW_DIV = ckgen_pkg::SLOW_OSC_CYCLES,
    parameter int WDT_DIV  = ckgen_pkg::WDT_OSC_CYCLES,
    parameter int CPU_DIV  = ckgen_pkg::CPU_RESET_DIVIDE
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    output logic            SLOW_OSC_CLOCK,
    output logic            WATCHDOG_OSC_CLOCK,
    output logic            FAST_OSC_ON,
    output logic            CPU_CLK_EN,
    output logic            PERIPHERAL_CLOCK_ON,
    output logic            FEEDBACK_RES_ON,
    output logic            SLOW_OSC_ON,
    output logic      [3:0] PLL_MULT,
    output logic      [2:0] PLL_REF_DIV,
    output logic            PLL_CFG_BAD
);

    // Register state
    logic [7:0] clock_mode_ctrl_one;
    logic [7:0] write_protect_register;
    logic [7:0] peripheral_clock_select;
    logic [7:0] pll_control;
    logic [7:0] processor_mode_two;
    logic [7:0] fast_osc_control_a;
    logic [7:0] fast_osc_control_b;
    logic [7:0] next_clock_mode_ctrl_one;
    logic [7:0] next_write_protect_register;
    logic [7:0] next_peripheral_clock_select;
    logic [7:0] next_pll_control;
    logic [7:0] next_processor_mode_two;
    logic [7:0] next_fast_osc_control_a;
    logic [7:0] next_fast_osc_control_b;
    logic [7:0] next_rdata;
    logic       unlocked;

    // Oscillator dividers and derived enables
    logic [15:0] slow_cnt;
    logic [15:0] wdt_cnt;
    logic [7:0]  cpu_cnt;
    logic [15:0] next_slow_cnt;
    logic [15:0] next_wdt_cnt;
    logic [7:0]  next_cpu_cnt;
    logic        next_slow_tick;
    logic        next_wdt_tick;
    logic        next_cpu_tick;

    // Decoded outputs
    logic [3:0] next_pll_mult;
    logic [2:0] next_pll_div;
    logic       next_pll_bad;
    // Next values for the level outputs
    logic       next_fast_on;
    logic       next_periph_on;
    logic       next_fb_on;
    logic       next_slow_on;

    // Writes to the clock group need the protect bit
    // The bit is only a gate; it never clears by itself
    assign unlocked = write_protect_register[ckgen_pkg::BIT_PROTECT_CLOCK];

    // Register writes and read mux
    always_comb begin
        next_clock_mode_ctrl_one     = clock_mode_ctrl_one;
        next_write_protect_register  = write_protect_register;
        next_peripheral_clock_select = peripheral_clock_select;
        next_pll_control             = pll_control;
        next_processor_mode_two      = processor_mode_two;
        next_fast_osc_control_a      = fast_osc_control_a;
        next_fast_osc_control_b      = fast_osc_control_b;
        next_rdata                   = 8'h00;

        // At most one register changes per cycle
        if (WR) begin
            unique case (ADDR)
                // Protect and mode two are never locked
                ckgen_pkg::ADDR_WRITE_PROTECT: begin
                    next_write_protect_register = WDATA;
                end
                ckgen_pkg::ADDR_PROCESSOR_MODE_TWO: begin
                    next_processor_mode_two = WDATA;
                end

                // Clock group: a locked write is dropped without trace
                ckgen_pkg::ADDR_CLOCK_MODE_CTRL_ONE: begin
                    if (unlocked) begin
                        next_clock_mode_ctrl_one = WDATA;
                    end
                end
                ckgen_pkg::ADDR_PERIPH_CLOCK_SELECT: begin
                    if (unlocked) begin
                        next_peripheral_clock_select = WDATA;
                    end
                end
                ckgen_pkg::ADDR_PLL_CONTROL: begin
                    if (unlocked) begin
                        next_pll_control = WDATA;
                    end
                end
                ckgen_pkg::ADDR_FAST_OSC_CONTROL_A: begin
                    if (unlocked) begin
                        next_fast_osc_control_a = WDATA;
                    end
                end
                ckgen_pkg::ADDR_FAST_OSC_CONTROL_B: begin
                    if (unlocked) begin
                        next_fast_osc_control_b = WDATA;
                    end
                end
                default: begin
                end
            endcase
        end

        // Unmapped addresses read as zero
        // Reads have no side effect, so they need no lock
        if (RD) begin
            unique case (ADDR)
                ckgen_pkg::ADDR_CLOCK_MODE_CTRL_ONE: begin
                    next_rdata = clock_mode_ctrl_one;
                end
                ckgen_pkg::ADDR_WRITE_PROTECT: begin
                    next_rdata = write_protect_register;
                end
                ckgen_pkg::ADDR_PERIPH_CLOCK_SELECT: begin
                    next_rdata = peripheral_clock_select;
                end
                ckgen_pkg::ADDR_PLL_CONTROL: begin
                    next_rdata = pll_control;
                end
                ckgen_pkg::ADDR_PROCESSOR_MODE_TWO: begin
                    next_rdata = processor_mode_two;
                end
                ckgen_pkg::ADDR_FAST_OSC_CONTROL_A: begin
                    next_rdata = fast_osc_control_a;
                end
                ckgen_pkg::ADDR_FAST_OSC_CONTROL_B: begin
                    next_rdata = fast_osc_control_b;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Register store; read data lasts one cycle only
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            clock_mode_ctrl_one     <= ckgen_pkg::RST_CLOCK_MODE_CTRL_ONE;
            write_protect_register  <= ckgen_pkg::RST_WRITE_PROTECT;
            peripheral_clock_select <= ckgen_pkg::RST_PERIPH_CLOCK_SELECT;
            pll_control             <= ckgen_pkg::RST_PLL_CONTROL;
            processor_mode_two      <= ckgen_pkg::RST_PROCESSOR_MODE_TWO;
            fast_osc_control_a      <= ckgen_pkg::RST_FAST_OSC_CONTROL_A;
            fast_osc_control_b      <= ckgen_pkg::RST_FAST_OSC_CONTROL_B;
            RDATA                   <= 8'h00;
        end else begin
            clock_mode_ctrl_one     <= next_clock_mode_ctrl_one;
            write_protect_register  <= next_write_protect_register;
            peripheral_clock_select <= next_peripheral_clock_select;
            pll_control             <= next_pll_control;
            processor_mode_two      <= next_processor_mode_two;
            fast_osc_control_a      <= next_fast_osc_control_a;
            fast_osc_control_b      <= next_fast_osc_control_b;
            RDATA                   <= next_rdata;
        end
    end

    // Oscillator dividers; slow source halts while stopped, watchdog never
    always_comb begin
        // Defaults: no pulse this cycle
        next_slow_cnt  = slow_cnt;
        next_slow_tick = 1'b0;
        next_wdt_tick  = 1'b0;
        next_cpu_tick  = 1'b0;
        next_cpu_cnt   = cpu_cnt;
        // Frozen, not cleared, so a restart keeps its phase
        if (!clock_mode_ctrl_one[ckgen_pkg::BIT_SLOW_OSC_STOP]) begin
            if (slow_cnt == 16'(SLOW_DIV - 1)) begin
                next_slow_cnt  = 16'h0000;
                next_slow_tick = 1'b1;
            end else begin
                next_slow_cnt = slow_cnt + 16'h0001;
            end
        end

        // Separate source so a stopped slow oscillator cannot starve it
        if (wdt_cnt == 16'(WDT_DIV - 1)) begin
            next_wdt_cnt  = 16'h0000;
            next_wdt_tick = 1'b1;
        end else begin
            next_wdt_cnt = wdt_cnt + 16'h0001;
        end

        // CPU clock is the slow source divided by CPU_DIV, eight by default
        if (next_slow_tick) begin
            if (cpu_cnt == 8'(CPU_DIV - 1)) begin
                next_cpu_cnt  = 8'h00;
                next_cpu_tick = 1'b1;
            end else begin
                next_cpu_cnt = cpu_cnt + 8'h01;
            end
        end
    end

    // Divider state and registered pulses
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            slow_cnt           <= 16'h0000;
            wdt_cnt            <= 16'h0000;
            cpu_cnt            <= 8'h00;
            SLOW_OSC_CLOCK     <= 1'b0;
            WATCHDOG_OSC_CLOCK <= 1'b0;
            CPU_CLK_EN         <= 1'b0;
        end else begin
            slow_cnt           <= next_slow_cnt;
            wdt_cnt            <= next_wdt_cnt;
            cpu_cnt            <= next_cpu_cnt;
            SLOW_OSC_CLOCK     <= next_slow_tick;
            WATCHDOG_OSC_CLOCK <= next_wdt_tick;
            CPU_CLK_EN         <= next_cpu_tick;
        end
    end

    // PLL factor decode; reserved codes flag an error, factor zero
    always_comb begin
        next_pll_bad = 1'b0;
        // Multiply field
        unique case (pll_control[ckgen_pkg::PLL_MUL_LSB +: 3])
            ckgen_pkg::PLL_MUL_X2: next_pll_mult = 4'h2;
            ckgen_pkg::PLL_MUL_X4: next_pll_mult = 4'h4;
            ckgen_pkg::PLL_MUL_X6: next_pll_mult = 4'h6;
            ckgen_pkg::PLL_MUL_X8: next_pll_mult = 4'h8;
            default: begin
                next_pll_mult = 4'h0;
                next_pll_bad  = 1'b1;
            end
        endcase

        // Reference divide field
        unique case (pll_control[ckgen_pkg::PLL_DIV_LSB +: 2])
            ckgen_pkg::PLL_DIV_1: next_pll_div = 3'h1;
            ckgen_pkg::PLL_DIV_2: next_pll_div = 3'h2;
            ckgen_pkg::PLL_DIV_4: next_pll_div = 3'h4;
            default: begin
                next_pll_div = 3'h0;
                next_pll_bad = 1'b1;
            end
        endcase
    end

    // Level controls taken from register bits
    always_comb begin
        next_fast_on   =
            fast_osc_control_a[ckgen_pkg::BIT_FAST_OSC_ENABLE];
        next_periph_on =
            processor_mode_two[ckgen_pkg::BIT_PERIPH_CLOCK_GATE];
        next_fb_on     =
            !clock_mode_ctrl_one[ckgen_pkg::BIT_FEEDBACK_RES_OFF];
        next_slow_on   =
            !clock_mode_ctrl_one[ckgen_pkg::BIT_SLOW_OSC_STOP];
    end

    // Level controls, registered so outputs stay glitch free
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PLL_MULT            <= 4'h0;
            PLL_REF_DIV         <= 3'h0;
            PLL_CFG_BAD         <= 1'b0;
            FAST_OSC_ON         <= 1'b0;
            PERIPHERAL_CLOCK_ON <= 1'b0;
            FEEDBACK_RES_ON     <= 1'b0;
            SLOW_OSC_ON         <= 1'b0;
        end else begin
            PLL_MULT            <= next_pll_mult;
            PLL_REF_DIV         <= next_pll_div;
            PLL_CFG_BAD         <= next_pll_bad;
            FAST_OSC_ON         <= next_fast_on;
            PERIPHERAL_CLOCK_ON <= next_periph_on;
            FEEDBACK_RES_ON     <= next_fb_on;
            SLOW_OSC_ON         <= next_slow_on;
        end
    end

endmodule

// ===== ckgen_pkg.sv
package ckgen_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CLOCK_MODE_CTRL_ONE  = 8'h07;
    localparam logic [7:0] ADDR_WRITE_PROTECT        = 8'h0a;
    localparam logic [7:0] ADDR_PERIPH_CLOCK_SELECT  = 8'h12;
    localparam logic [7:0] ADDR_PLL_CONTROL          = 8'h1c;
    localparam logic [7:0] ADDR_PROCESSOR_MODE_TWO   = 8'h1e;
    localparam logic [7:0] ADDR_FAST_OSC_CONTROL_A   = 8'h22;
    localparam logic [7:0] ADDR_FAST_OSC_CONTROL_B   = 8'h24;

    // Field positions
    localparam int BIT_PROTECT_CLOCK     = 0;
    localparam int BIT_FEEDBACK_RES_OFF  = 3;
    localparam int BIT_SLOW_OSC_STOP     = 4;
    localparam int BIT_PERIPH_CLOCK_GATE = 5;
    localparam int BIT_FAST_OSC_ENABLE   = 0;
    localparam int PLL_MUL_LSB           = 0;
    localparam int PLL_DIV_LSB           = 4;

    // Reset values
    localparam logic [7:0] RST_CLOCK_MODE_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_WRITE_PROTECT       = 8'h00;
    localparam logic [7:0] RST_PERIPH_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] RST_PLL_CONTROL         = 8'h01;
    localparam logic [7:0] RST_PROCESSOR_MODE_TWO  = 8'h01;
    localparam logic [7:0] RST_FAST_OSC_CONTROL_A  = 8'h00;
    localparam logic [7:0] RST_FAST_OSC_CONTROL_B  = 8'h00;

    // Multiply and reference-divide codes
    localparam logic [2:0] PLL_MUL_X2 = 3'h1;
    localparam logic [2:0] PLL_MUL_X4 = 3'h2;
    localparam logic [2:0] PLL_MUL_X6 = 3'h3;
    localparam logic [2:0] PLL_MUL_X8 = 3'h4;
    localparam logic [1:0] PLL_DIV_1  = 2'h0;
    localparam logic [1:0] PLL_DIV_2  = 2'h1;
    localparam logic [1:0] PLL_DIV_4  = 2'h2;

    // Timing
    localparam int SYS_CLK_HZ       = 20000000;
    localparam int FAST_OSC_HZ      = 40000000;
    localparam int SLOW_OSC_HZ      = 125000;
    localparam int WDT_OSC_HZ       = 125000;
    localparam int SLOW_OSC_CYCLES  = SYS_CLK_HZ / SLOW_OSC_HZ;
    localparam int WDT_OSC_CYCLES   = SYS_CLK_HZ / WDT_OSC_HZ;
    localparam int CPU_RESET_DIVIDE = 8;
endpackage

// ===== ckgen_clock_control_sva.sv
`timescale 1ns/100ps
module ckgen_clock_control_sva #(
    parameter int SLOW_DIV = 160,
    parameter int WDT_DIV  = 160,
    parameter int CPU_DIV  = 8
) (
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       SLOW_OSC_CLOCK,
    input wire logic       WATCHDOG_OSC_CLOCK,
    input wire logic       FAST_OSC_ON,
    input wire logic       CPU_CLK_EN,
    input wire logic       PERIPHERAL_CLOCK_ON,
    input wire logic       FEEDBACK_RES_ON,
    input wire logic       SLOW_OSC_ON,
    input wire logic [3:0] PLL_MULT,
    input wire logic [2:0] PLL_REF_DIV,
    input wire logic       PLL_CFG_BAD
);
    localparam logic [3:0] MUL [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                       4'h8, 4'h0, 4'h0, 4'h0};
    localparam logic [2:0] DIV [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic       prot, next_prot, wseen, next_wseen;
    logic [3:0] ncpu, next_ncpu;
    logic [7:0] wcnt, next_wcnt;

    // Shadow protect bit, slow pulses per CPU tick, watchdog spacing
    always_comb begin
        next_prot  = (WR && ADDR == 8'h0a) ? WDATA[0] : prot;
        next_ncpu  = CPU_CLK_EN ? 4'h0 : ncpu + {3'h0, SLOW_OSC_CLOCK};
        next_wcnt  = WATCHDOG_OSC_CLOCK ? 8'h01 : wcnt + {7'h0, wcnt != 8'hff};
        next_wseen = wseen | WATCHDOG_OSC_CLOCK;
    end

    // Cleared by reset so the first pulse after release is not judged
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prot  <= 1'b0;
            ncpu  <= 4'h0;
            wcnt  <= 8'h00;
            wseen <= 1'b0;
        end else begin
            prot  <= next_prot;
            ncpu  <= next_ncpu;
            wcnt  <= next_wcnt;
            wseen <= next_wseen;
        end
    end

    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    periph_gate_a: assert property (
        WR && ADDR == 8'h1e |-> ##2 PERIPHERAL_CLOCK_ON == $past(WDATA[5], 2))
        else $error("peripheral clock gate wrong");
    res_slow_a: assert property (
        WR && ADDR == 8'h07 && prot |-> ##2 FEEDBACK_RES_ON ==
        !$past(WDATA[3], 2) && SLOW_OSC_ON == !$past(WDATA[4], 2))
        else $error("feedback or slow stop wrong");
    refused_write_a: assert property (
        WR && !prot && (ADDR == 8'h07 || ADDR == 8'h1c || ADDR == 8'h22)
        |-> ##2 FEEDBACK_RES_ON == $past(FEEDBACK_RES_ON, 2) &&
        PLL_MULT == $past(PLL_MULT, 2) && FAST_OSC_ON == $past(FAST_OSC_ON, 2))
        else $error("protected write took effect");
    pll_mult_a: assert property (
        WR && ADDR == 8'h1c && prot |-> ##2 PLL_MULT == MUL[$past(WDATA[2:0], 2)])
        else $error("multiply decode wrong");
    pll_div_a: assert property (
        WR && ADDR == 8'h1c && prot |-> ##2
        PLL_REF_DIV == DIV[$past(WDATA[5:4], 2)])
        else $error("reference divide decode wrong");
    pll_bad_a: assert property (
        $past(RST_N) && $past(RST_N, 2) && $past(RST_N, 3) |->
        PLL_CFG_BAD == (PLL_MULT == 4'h0 || PLL_REF_DIV == 3'h0))
        else $error("bad setting flag wrong");
    cpu_div_a: assert property (
        SLOW_OSC_CLOCK |-> CPU_CLK_EN == (ncpu == CPU_DIV - 1))
        else $error("CPU tick not every nth slow pulse");
    cpu_tied_a: assert property (
        CPU_CLK_EN |-> SLOW_OSC_CLOCK)
        else $error("CPU tick without slow pulse");
    wdt_period_a: assert property (
        wseen |-> WATCHDOG_OSC_CLOCK == (wcnt == WDT_DIV))
        else $error("watchdog pulse spacing wrong");
    rdata_idle_a: assert property (
        !$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
endmodule

bind ckgen_clock_control ckgen_clock_control_sva #(.SLOW_DIV(SLOW_DIV),
    .WDT_DIV(WDT_DIV), .CPU_DIV(CPU_DIV)) i_ckgen_clock_control_sva (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SLOW_OSC_CLOCK(SLOW_OSC_CLOCK),
    .WATCHDOG_OSC_CLOCK(WATCHDOG_OSC_CLOCK), .FAST_OSC_ON(FAST_OSC_ON),
    .CPU_CLK_EN(CPU_CLK_EN), .PERIPHERAL_CLOCK_ON(PERIPHERAL_CLOCK_ON),
    .FEEDBACK_RES_ON(FEEDBACK_RES_ON), .SLOW_OSC_ON(SLOW_OSC_ON),
    .PLL_MULT(PLL_MULT), .PLL_REF_DIV(PLL_REF_DIV), .PLL_CFG_BAD(PLL_CFG_BAD));

// ===== ckgen_clock_control_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("Error %s exp %0h got %0h", n, e, g); end end
module ckgen_clock_control_tb;
    logic       sys_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] rdata, rv;
    logic       s_clk, w_clk, fast_on, cpu_en, per_on, fb_on, s_on, bad;
    logic [3:0] mult;
    logic [2:0] rdiv;
    int         bad_count, samples_checked, cyc, ns, nw, nc;

    // Short divider counts keep the pulse checks brief
    ckgen_clock_control #(.SLOW_DIV(4), .WDT_DIV(4), .CPU_DIV(2))
        i_ckgen_clock_control (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SLOW_OSC_CLOCK(s_clk), .WATCHDOG_OSC_CLOCK(w_clk),
        .FAST_OSC_ON(fast_on), .CPU_CLK_EN(cpu_en),
        .PERIPHERAL_CLOCK_ON(per_on), .FEEDBACK_RES_ON(fb_on),
        .SLOW_OSC_ON(s_on), .PLL_MULT(mult), .PLL_REF_DIV(rdiv),
        .PLL_CFG_BAD(bad));

    always #25 sys_clk = ~sys_clk;

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end

    // Write, then let the level outputs settle one cycle past the store
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask

    task automatic count(input int n);
        ns = 0;
        nw = 0;
        nc = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            ns += int'(s_clk);
            nw += int'(w_clk);
            nc += int'(cpu_en);
        end
    endtask

    task automatic t_reset;
        logic [7:0] ra [7] = '{8'h07, 8'h0a, 8'h12, 8'h1c, 8'h1e, 8'h22, 8'h24};
        logic [7:0] rr [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
        `CHK("feedback", 1'b1, fb_on)
        `CHK("slow on", 1'b1, s_on)
        `CHK("mult", 4'h2, mult)
        `CHK("refdiv", 3'h1, rdiv)
        `CHK("periph", 1'b0, per_on)
        count(16);
        `CHK("slow pulses", 4, ns)
        `CHK("wdt pulses", 4, nw)
        `CHK("cpu ticks", 2, nc)
        for (int i = 0; i < 7; i++) begin
            rd_reg(ra[i]);
            `CHK("reset value", rr[i], rv)
        end
        $display("test reset done");
    endtask

    task automatic t_protect;
        wr_reg(8'h07, 8'h18);
        wr_reg(8'h1c, 8'h24);
        wr_reg(8'h22, 8'h01);
        wr_reg(8'h30, 8'hff);
        `CHK("feedback", 1'b1, fb_on)
        `CHK("mult", 4'h2, mult)
        `CHK("fast on", 1'b0, fast_on)
        rd_reg(8'h07);
        `CHK("mode one", 8'h00, rv)
        rd_reg(8'h30);
        `CHK("unmapped", 8'h00, rv)
        wr_reg(8'h1e, 8'h20);
        `CHK("periph", 1'b1, per_on)
        wr_reg(8'h1e, 8'h00);
        `CHK("periph", 1'b0, per_on)
        $display("test protect done");
    endtask

    task automatic t_mode;
        wr_reg(8'h0a, 8'h01);
        wr_reg(8'h07, 8'h08);
        `CHK("feedback", 1'b0, fb_on)
        wr_reg(8'h07, 8'h10);
        `CHK("feedback", 1'b1, fb_on)
        `CHK("slow on", 1'b0, s_on)
        count(16);
        `CHK("slow pulses", 0, ns)
        `CHK("wdt pulses", 4, nw)
        wr_reg(8'h07, 8'h00);
        count(16);
        `CHK("slow pulses", 4, ns)
        wr_reg(8'h22, 8'h01);
        `CHK("fast on", 1'b1, fast_on)
        wr_reg(8'h24, 8'ha5);
        rd_reg(8'h24);
        `CHK("fast b", 8'ha5, rv)
        $display("test mode done");
    endtask

    task automatic t_pll;
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 4; d++) begin
                wr_reg(8'h1c, {2'h0, d[1:0], 1'b0, m[2:0]});
                `CHK("mult", (m > 0 && m < 5) ? 4'(2 * m) : 4'h0, mult)
                `CHK("refdiv", (d == 3) ? 3'h0 : 3'(1 << d), rdiv)
                `CHK("bad", m == 0 || m > 4 || d == 3, bad)
            end
        end
        $display("test pll done");
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        t_reset();
        t_protect();
        t_mode();
        t_pll();
        close_out();
    end
endmodule
